// file: rtl/accel_engine.sv
// Overview of operation
// - Four separate 16KB local memories hold all source and destination samples.
// - Sequencer starts, loops and stops the engine and swaps triggers.
// - Input formatter reads samples from one selected local memory.
// - Input side takes 16-bit or 32-bit samples, transposed, with scaling.
// - Input I and Q become 24 bits: 16-bit halves are sign-extended, 32-bit words truncated.
// - Output formatter writes results into the chosen destination memory.
// - Output side writes 16-bit (truncated) or 32-bit (sign-extended), transposed, scaled.
// - Compute unit offers window, magnitude, log2 and detection per set; FFT passes samples through.
// - Compute unit takes one sample per clock, output after op-dependent latency.
// - Parameter-set store is a 512-byte RAM of chained settings.
// - Up to 16 sets run in order, repeatable in a loop.
// - End of each set may raise an interrupt and/or DMA trigger.
// - Each set occupies eight 32-bit words of the store.
// - Everything runs on one clock with no crossings.
// - Sequencer copies one set into working registers, then executes it.
// - After the last set, restart at the first until loops run out.
// - A set holds mode, addresses, count, formatting and trigger mode.
// - While running, one source sample is read each clock until count samples are read.
// - Formatter to compute path is 24-bit complex, one sample per clock.
// - Compute to output path is 24-bit complex, one result per clock.
// - First and last set indices choose the contiguous range per pass.
// - Loop count 0 runs nothing, 4095 loops forever, else that many passes.
// - After all loops finish, a sequence-done interrupt is raised.
`timescale 1ns/1ps
`default_nettype none
`include "accel_defs.svh"
module accel_engine (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic enable_in,
   input wire logic [3:0] first_set_index_in,
   input wire logic [3:0] last_set_index_in,
   input wire logic [11:0] loop_repeat_count_in,
   input wire logic sw_trigger_in,
   input wire logic adc_switch_in,
   input wire logic dma_done_in,
   input wire logic pset_wr_in,
   input wire logic [6:0] pset_addr_in,
   input wire logic [31:0] pset_wdata_in,
   input wire logic mem_wr_in,
   input wire logic [12:0] mem_addr_in,
   input wire logic [63:0] mem_wdata_in,
   output logic [63:0] mem_rdata_out,
   output logic busy_out,
   output logic [3:0] set_index_out,
   output logic set_done_irq_out,
   output logic dma_trig_out,
   output logic sequence_done_interrupt_out
);
   accel_pkg::seq_state_t state_q;
   logic [3:0] set_q;
   logic [11:0] loops_q;
   logic [2:0] ld_q;
   logic [31:0] cfg_w_q [0:4];
   logic [31:0] ps_rd;
   accel_pkg::set_ctrl_t ctrl;
   logic [11:0] cnt, rd_cnt_q, wr_cnt_q;
   logic [12:0] rd_off_q, wr_off_q, eng_raddr, eng_waddr, rd_step, wr_step;
   logic eng_re, eng_we, rv_q, trig_hit, last_loop;
   logic [1:0] rbank_q, hbank_q;
   logic [63:0] bank_rd [0:3];
   logic [63:0] rd_w, wr_w;
   accel_pkg::cplx_t in_smp, out_smp;
   logic out_valid;

   // Working copy of the current set
   assign ctrl = accel_pkg::set_ctrl_t'(cfg_w_q[`W_CTRL]);
   assign cnt = cfg_w_q[`W_CNT][`CNT_W-1:0];
   assign rd_step = ctrl.in_tr ? cfg_w_q[`W_SRC][`STRIDE_LSB+12:`STRIDE_LSB] : 13'h1;
   assign wr_step = ctrl.out_tr ? cfg_w_q[`W_DST][`STRIDE_LSB+12:`STRIDE_LSB] : 13'h1;
   assign eng_raddr = cfg_w_q[`W_SRC][12:0] + rd_off_q;
   assign eng_waddr = cfg_w_q[`W_DST][12:0] + wr_off_q;
   assign eng_re = (state_q == accel_pkg::S_RUN) && (rd_cnt_q < cnt);
   assign eng_we = (state_q == accel_pkg::S_RUN) && out_valid;
   assign last_loop = (loop_repeat_count_in != `LOOP_ENDLESS)
      && (loops_q + 12'h1 == loop_repeat_count_in);

   // Trigger mode gates the start of computation
   always_comb begin
      case (ctrl.trig)
         `TRIG_IMM: trig_hit = 1'b1;
         `TRIG_SW: trig_hit = sw_trigger_in;
         `TRIG_ADC: trig_hit = adc_switch_in;
         `TRIG_DMA: trig_hit = dma_done_in;
         default: trig_hit = 1'b1;
      endcase
   end

   // Parameter-set store, written by the processor only
   local_ram #(
      .DW(`PSET_DW),
      .AW(`PSET_AW)
   ) u_pset (
      .clk_in(mclk_in),
      .wr_en_in(pset_wr_in),
      .wr_addr_in(pset_addr_in),
      .wr_data_in(pset_wdata_in),
      .rd_addr_in({set_q, ld_q}),
      .rd_data_out(ps_rd)
   );

   // Four banks; the engine wins over host on the bank it uses
   for (genvar b = 0; b < `BANKS; b++) begin : g_bank
      logic we, eng_wb, eng_rb;
      assign eng_wb = eng_we && (eng_waddr[12:11] == 2'(b));
      assign eng_rb = (state_q == accel_pkg::S_RUN) && (eng_raddr[12:11] == 2'(b));
      assign we = eng_wb || (mem_wr_in && mem_addr_in[12:11] == 2'(b)
         && !(state_q == accel_pkg::S_RUN && cfg_w_q[`W_DST][12:11] == 2'(b)));
      local_ram #(
         .DW(`MEM_DW),
         .AW(`BANK_AW)
      ) u_mem (
         .clk_in(mclk_in),
         .wr_en_in(we),
         .wr_addr_in(eng_wb ? eng_waddr[10:0] : mem_addr_in[10:0]),
         .wr_data_in(eng_wb ? wr_w : mem_wdata_in),
         .rd_addr_in(eng_rb ? eng_raddr[10:0] : mem_addr_in[10:0]),
         .rd_data_out(bank_rd[b])
      );
   end

   // Sequencer: one clock domain throughout
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= accel_pkg::S_IDLE;
         set_q <= 4'h0;
         loops_q <= 12'h000;
         ld_q <= 3'h0;
      end else if (!enable_in) begin
         state_q <= accel_pkg::S_IDLE; // Disable aborts at any point
         ld_q <= 3'h0;
      end else begin
         case (state_q)
            accel_pkg::S_IDLE: begin
               if (loop_repeat_count_in != `LOOP_NONE) begin
                  state_q <= accel_pkg::S_LOAD;
                  set_q <= first_set_index_in;
                  loops_q <= 12'h000;
                  ld_q <= 3'h0;
               end
            end
            accel_pkg::S_LOAD: begin
               ld_q <= ld_q + 3'h1;
               if (ld_q == `LOAD_WORDS) begin
                  state_q <= accel_pkg::S_TRIG;
               end
            end
            accel_pkg::S_TRIG: begin
               if (trig_hit) begin
                  state_q <= accel_pkg::S_RUN;
               end
            end
            accel_pkg::S_RUN: begin
               if (rd_cnt_q == cnt && wr_cnt_q == cnt) begin
                  state_q <= accel_pkg::S_NEXT;
               end
            end
            accel_pkg::S_NEXT: begin
               ld_q <= 3'h0;
               if (set_q != last_set_index_in) begin
                  set_q <= set_q + 4'h1;
                  state_q <= accel_pkg::S_LOAD;
               end else if (!last_loop) begin
                  set_q <= first_set_index_in;
                  loops_q <= loops_q + 12'h1;
                  state_q <= accel_pkg::S_LOAD;
               end else begin
                  state_q <= accel_pkg::S_HOLD; // Stays until enable drops
               end
            end
            accel_pkg::S_HOLD: state_q <= accel_pkg::S_HOLD;
            default: state_q <= accel_pkg::S_IDLE;
         endcase
      end
   end

   // Capture the fetched words; read data trails the address by one clock
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int k = 0; k < 5; k++) begin
            cfg_w_q[k] <= 32'h0;
         end
      end else if (state_q == accel_pkg::S_LOAD && ld_q != 3'h0) begin
         cfg_w_q[ld_q - 3'h1] <= ps_rd;
      end
   end

   // Read and write walkers of the running set
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_cnt_q <= 12'h000;
         wr_cnt_q <= 12'h000;
         rd_off_q <= 13'h0;
         wr_off_q <= 13'h0;
      end else if (state_q != accel_pkg::S_RUN) begin
         rd_cnt_q <= 12'h000;
         wr_cnt_q <= 12'h000;
         rd_off_q <= 13'h0;
         wr_off_q <= 13'h0;
      end else begin
         if (eng_re) begin
            rd_cnt_q <= rd_cnt_q + 12'h1;
            rd_off_q <= rd_off_q + rd_step;
         end
         if (eng_we) begin
            wr_cnt_q <= wr_cnt_q + 12'h1;
            wr_off_q <= wr_off_q + wr_step;
         end
      end
   end

   // Read strobe and bank aligned with the RAM output
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rv_q <= 1'b0;
         rbank_q <= 2'h0;
         hbank_q <= 2'h0;
      end else begin
         rv_q <= eng_re;
         rbank_q <= eng_raddr[12:11];
         hbank_q <= mem_addr_in[12:11];
      end
   end

   // Input formatter: 32-bit words shift right, 16-bit halves sign-extend then shift left
   assign rd_w = bank_rd[rbank_q];
   always_comb begin
      if (ctrl.in_32) begin
         in_smp.i = 24'($signed(rd_w[31:0]) >>> ctrl.in_scale);
         in_smp.q = 24'($signed(rd_w[63:32]) >>> ctrl.in_scale);
      end else begin
         in_smp.i = 24'($signed(rd_w[15:0])) <<< ctrl.in_scale;
         in_smp.q = 24'($signed(rd_w[31:16])) <<< ctrl.in_scale;
      end
   end

   compute_core u_core (
      .clk_in(mclk_in),
      .nrst_in(nrst_in),
      .op_in(ctrl.op),
      .param_in(cfg_w_q[`W_PARAM][23:0]),
      .in_valid_in(rv_q),
      .in_smp_in(in_smp),
      .out_valid_out(out_valid),
      .out_smp_out(out_smp)
   );

   // Output formatter; 16-bit form truncates after the right shift, no saturation
   always_comb begin
      if (ctrl.out_32) begin
         wr_w = {32'($signed(out_smp.q)) <<< ctrl.out_scale,
                 32'($signed(out_smp.i)) <<< ctrl.out_scale};
      end else begin
         wr_w = {32'h0, 16'(out_smp.q >>> ctrl.out_scale), 16'(out_smp.i >>> ctrl.out_scale)};
      end
   end

   // Registered status and event pulses
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         busy_out <= 1'b0;
         set_index_out <= 4'h0;
         set_done_irq_out <= 1'b0;
         dma_trig_out <= 1'b0;
         sequence_done_interrupt_out <= 1'b0;
         mem_rdata_out <= 64'h0;
      end else begin
         busy_out <= enable_in && state_q != accel_pkg::S_IDLE && state_q != accel_pkg::S_HOLD;
         set_index_out <= set_q;
         set_done_irq_out <= enable_in && state_q == accel_pkg::S_NEXT && ctrl.irq_en;
         dma_trig_out <= enable_in && state_q == accel_pkg::S_NEXT && ctrl.dma_trig_en;
         sequence_done_interrupt_out <= enable_in && state_q == accel_pkg::S_NEXT
            && set_q == last_set_index_in && last_loop;
         mem_rdata_out <= bank_rd[hbank_q];
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   property p_read_rate;
      (eng_re && enable_in) |=> (rd_cnt_q == $past(rd_cnt_q) + 12'h1 && rv_q);
   endproperty
   a_read_rate: assert property (p_read_rate) else $error("source read skipped");
   property p_drain;
      (state_q == accel_pkg::S_NEXT) |-> (wr_cnt_q == cnt && $past(state_q) == accel_pkg::S_RUN);
   endproperty
   a_drain: assert property (p_drain) else $error("set left before last write");
   property p_zero_loops;
      (state_q == accel_pkg::S_IDLE && loop_repeat_count_in == `LOOP_NONE) |=>
         (state_q == accel_pkg::S_IDLE);
   endproperty
   a_zero_loops: assert property (p_zero_loops) else $error("ran with zero loops");
   property p_range;
      (state_q == accel_pkg::S_RUN && first_set_index_in <= last_set_index_in
         && $stable(first_set_index_in))
         |-> (set_q >= first_set_index_in && set_q <= last_set_index_in);
   endproperty
   a_range: assert property (p_range) else $error("set outside range");
   property p_load;
      (state_q == accel_pkg::S_LOAD && ld_q == 3'h0 && enable_in) ##1 enable_in[*5]
         |=> (state_q == accel_pkg::S_TRIG);
   endproperty
   a_load: assert property (p_load) else $error("load length wrong");
   property p_restart;
      (state_q == accel_pkg::S_NEXT && enable_in && set_q == last_set_index_in
         && loop_repeat_count_in == `LOOP_ENDLESS)
         |=> (set_q == $past(first_set_index_in) && state_q == accel_pkg::S_LOAD);
   endproperty
   a_restart: assert property (p_restart) else $error("no restart at first set");
   property p_seq_done;
      sequence_done_interrupt_out |-> $past(state_q == accel_pkg::S_NEXT && last_loop);
   endproperty
   a_seq_done: assert property (p_seq_done) else $error("done pulse without end");
   property p_set_irq;
      (enable_in && state_q == accel_pkg::S_NEXT && ctrl.irq_en) |=> set_done_irq_out;
   endproperty
   a_set_irq: assert property (p_set_irq) else $error("set interrupt missing");
   c_seq_done: cover property (sequence_done_interrupt_out);
   c_restart: cover property (state_q == accel_pkg::S_NEXT && loops_q != 12'h0);
   c_sw_trig: cover property (state_q == accel_pkg::S_TRIG && ctrl.trig == `TRIG_SW ##1
      state_q == accel_pkg::S_RUN);
endmodule // accel_engine
`default_nettype wire

// file: rtl/accel_defs.svh
`ifndef ACCEL_DEFS_SVH
`define ACCEL_DEFS_SVH
// Memory geometry: 16KB bank = 2048 words of 64 bits
`define BANKS 4
`define BANK_AW 11
`define MEM_AW 13
`define MEM_DW 64
`define CPLX_W 24
// Parameter-set store: 16 sets of 8 words of 32 bits = 512 bytes
`define SETS 16
`define SET_WORDS 8
`define PSET_AW 7
`define PSET_DW 32
// Words fetched per set and their indices inside the set
`define LOAD_WORDS 3'h5
`define W_CTRL 0
`define W_SRC 1
`define W_DST 2
`define W_CNT 3
`define W_PARAM 4
`define STRIDE_LSB 16
`define CNT_W 12
// Loop count special values
`define LOOP_NONE 12'h000
`define LOOP_ENDLESS 12'hfff
// Trigger modes
`define TRIG_IMM 3'h0
`define TRIG_SW 3'h1
`define TRIG_ADC 3'h2
`define TRIG_DMA 3'h3
// Operation modes
`define OP_COPY 3'h0
`define OP_WINDOW 3'h1
`define OP_FFT 3'h2
`define OP_MAG 3'h3
`define OP_LOG2 3'h4
`define OP_CFAR 3'h5
`define WIN_FRAC 15
`endif

// file: rtl/accel_pkg.sv
package accel_pkg;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_LOAD = 3'b001,
      S_TRIG = 3'b010,
      S_RUN = 3'b011,
      S_NEXT = 3'b100,
      S_HOLD = 3'b101
   } seq_state_t;
   typedef struct packed {
      logic signed [23:0] q;
      logic signed [23:0] i;
   } cplx_t;
   typedef struct packed {
      logic [13:0] spare;
      logic dma_trig_en;
      logic irq_en;
      logic [2:0] out_scale;
      logic [2:0] in_scale;
      logic out_tr;
      logic in_tr;
      logic out_32;
      logic in_32;
      logic [2:0] op;
      logic [2:0] trig;
   } set_ctrl_t;
endpackage

// file: rtl/local_ram.sv
`timescale 1ns/1ps
`default_nettype none
// One write port, one read port, registered read data
module local_ram #(
   parameter int DW = 64,
   parameter int AW = 11
) (
   input wire logic clk_in,
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [DW-1:0] wr_data_in,
   input wire logic [AW-1:0] rd_addr_in,
   output logic [DW-1:0] rd_data_out
);
   logic [DW-1:0] mem_q [0:(1<<AW)-1];

   // Array has no reset so it maps onto block RAM
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_q[rd_addr_in];
   end
endmodule // local_ram
`default_nettype wire

// file: rtl/compute_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "accel_defs.svh"
// Streaming compute unit: one sample in per clock, latency set by the operation
module compute_core (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [2:0] op_in,
   input wire logic [23:0] param_in,
   input wire logic in_valid_in,
   input wire accel_pkg::cplx_t in_smp_in,
   output logic out_valid_out,
   output accel_pkg::cplx_t out_smp_out
);
   logic [2:0] v_q;
   accel_pkg::cplx_t s1_q, s2w_q;
   logic [23:0] mag2_q, log3_q, det3_q, ai, aq;
   logic [24:0] mag_d;
   logic signed [39:0] pi, pq;
   logic [4:0] lg;

   // Valid pipeline; every stage advances each clock
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         v_q <= 3'h0;
      end else begin
         v_q <= {v_q[1:0], in_valid_in};
      end
   end

   // Window product, sum-of-abs magnitude, msb position and threshold
   always_comb begin
      ai = in_abs(s1_q.i);
      aq = in_abs(s1_q.q);
      mag_d = {1'b0, ai} + {1'b0, aq};
      pi = s1_q.i * $signed({1'b0, param_in[14:0]});
      pq = s1_q.q * $signed({1'b0, param_in[14:0]});
      lg = 5'h0;
      for (int k = 0; k < 24; k++) begin
         if (mag2_q[k]) begin
            lg = 5'(k);
         end
      end
   end

   function automatic logic [23:0] in_abs(input logic signed [23:0] x);
      in_abs = x[23] ? 24'(-x) : 24'(x);
   endfunction

   // Data stages carry no reset; valid alone marks them
   always_ff @(posedge clk_in) begin
      s1_q <= in_smp_in;
      s2w_q.i <= 24'(pi >>> `WIN_FRAC);
      s2w_q.q <= 24'(pq >>> `WIN_FRAC);
      mag2_q <= mag_d[24] ? 24'hffffff : mag_d[23:0]; // Saturate, never wrap
      log3_q <= {11'h0, lg, 8'h00};
      det3_q <= (mag2_q > param_in) ? 24'h000001 : 24'h000000;
   end

   // Result tap depends on the operation of the running set; FFT kernel is a pass stage here
   always_comb begin
      out_valid_out = v_q[0];
      out_smp_out = s1_q;
      case (op_in)
         `OP_WINDOW: begin
            out_valid_out = v_q[1];
            out_smp_out = s2w_q;
         end
         `OP_MAG: begin
            out_valid_out = v_q[1];
            out_smp_out = {24'h0, mag2_q};
         end
         `OP_LOG2: begin
            out_valid_out = v_q[2];
            out_smp_out = {24'h0, log3_q};
         end
         `OP_CFAR: begin
            out_valid_out = v_q[2];
            out_smp_out = {24'h0, det3_q};
         end
         default: begin
            out_valid_out = v_q[0];
            out_smp_out = s1_q;
         end
      endcase
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   property p_copy_lat;
      (in_valid_in && op_in == `OP_COPY) |=> (out_valid_out && out_smp_out == $past(in_smp_in));
   endproperty
   a_copy_lat: assert property (p_copy_lat) else $error("copy result late or wrong");
   property p_mag;
      (in_valid_in && op_in == `OP_MAG && in_smp_in.q == 24'h0 && !in_smp_in.i[23])
         |-> ##2 (out_valid_out && out_smp_out.i == $past(in_smp_in.i, 2));
   endproperty
   a_mag: assert property (p_mag) else $error("magnitude result wrong");
endmodule // compute_core
`default_nettype wire

// file: verification/dma_partner.sv
`timescale 1ns/1ps
`default_nettype none
// DMA channel: a transfer starts on the engine's trigger and signals completion
module dma_partner (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic trig_in,
   input wire logic [3:0] delay_in,
   output logic done_out
);
   logic armed_q;
   logic [3:0] wait_q;
   logic [3:0] hold_q;

   // Completion is held for a while since the engine samples it only while in trigger wait
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         armed_q <= 1'b0;
         wait_q <= 4'h0;
         hold_q <= 4'h0;
      end else if (trig_in) begin
         armed_q <= 1'b1;
         wait_q <= delay_in;
      end else if (armed_q && wait_q == 4'h0) begin
         armed_q <= 1'b0;
         hold_q <= 4'hc;
      end else begin
         if (armed_q) wait_q <= wait_q - 4'h1;
         if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
      end
   end

   assign done_out = (hold_q != 4'h0);
endmodule // dma_partner
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic mclk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic enable_in = 1'b0;
   logic [3:0] first_set_index_in = 4'h0;
   logic [3:0] last_set_index_in = 4'h0;
   logic [11:0] loop_repeat_count_in = 12'h000;
   logic sw_trigger_in = 1'b0;
   logic adc_switch_in = 1'b0;
   logic dma_done_in;
   logic pset_wr_in = 1'b0;
   logic [6:0] pset_addr_in = 7'h00;
   logic [31:0] pset_wdata_in = 32'h0;
   logic mem_wr_in = 1'b0;
   logic [12:0] mem_addr_in = 13'h0;
   logic [63:0] mem_wdata_in = 64'h0;
   logic [63:0] mem_rdata_out;
   logic busy_out;
   logic [3:0] set_index_out;
   logic set_done_irq_out;
   logic dma_trig_out;
   logic sequence_done_interrupt_out;
   logic [3:0] dma_delay = 4'h0;
   logic [63:0] src_words[$];
   int fail_count = 0;
   int n_compared = 0;
   int irqs;
   int trigs;
   int done;
   logic [2:0] trig;

   always #2 mclk_in = ~mclk_in;

   accel_engine uut (.mclk_in(mclk_in), .nrst_in(nrst_in), .enable_in(enable_in),
      .first_set_index_in(first_set_index_in), .last_set_index_in(last_set_index_in),
      .loop_repeat_count_in(loop_repeat_count_in), .sw_trigger_in(sw_trigger_in),
      .adc_switch_in(adc_switch_in), .dma_done_in(dma_done_in), .pset_wr_in(pset_wr_in),
      .pset_addr_in(pset_addr_in), .pset_wdata_in(pset_wdata_in), .mem_wr_in(mem_wr_in),
      .mem_addr_in(mem_addr_in), .mem_wdata_in(mem_wdata_in), .mem_rdata_out(mem_rdata_out),
      .busy_out(busy_out), .set_index_out(set_index_out), .set_done_irq_out(set_done_irq_out),
      .dma_trig_out(dma_trig_out), .sequence_done_interrupt_out(sequence_done_interrupt_out));

   dma_partner dma (.clk_in(mclk_in), .nrst_in(nrst_in), .trig_in(dma_trig_out),
      .delay_in(dma_delay), .done_out(dma_done_in));

   task automatic tick;
      @(posedge mclk_in);
      #1;
   endtask

   task automatic stop_test;
      if (fail_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   // Reference result of one 16-bit source word, unit scaling, zero parameter word
   function automatic logic [63:0] model(input int op, input logic [63:0] w);
      int si, sq, m, r;
      si = int'($signed(w[15:0]));
      sq = int'($signed(w[31:16]));
      m = ((si < 0) ? -si : si) + ((sq < 0) ? -sq : sq);
      r = 0;
      for (int k = 0; k < 24; k++) begin
         if (m >= (1 << k)) begin
            r = k;
         end
      end
      case (op)
         0, 2: model = {32'h0, w[31:0]};
         1: model = 64'h0;
         3: model = {48'h0, 16'(m)};
         4: model = {48'h0, 16'(r << 8)};
         default: model = {63'h0, 1'(m > 0)};
      endcase
   endfunction

   task automatic pset_wr(input logic [6:0] a, input logic [31:0] d);
      pset_wr_in = 1'b1;
      pset_addr_in = a;
      pset_wdata_in = d;
      tick;
   endtask

   // One set: control, source, destination with unit stride, count
   task automatic set_cfg(input logic [3:0] s, input logic [31:0] ctrl,
                          input logic [12:0] src, input logic [12:0] dst, input logic [11:0] cnt);
      pset_wr({s, 3'h0}, ctrl);
      pset_wr({s, 3'h1}, {3'h0, 13'h0001, 3'h0, src});
      pset_wr({s, 3'h2}, {3'h0, 13'h0001, 3'h0, dst});
      pset_wr({s, 3'h3}, {20'h0, cnt});
      pset_wr({s, 3'h4}, 32'h0);
      pset_wr_in = 1'b0;
      tick;
   endtask

   task automatic mem_read(input logic [12:0] a, input logic [63:0] exp);
      mem_addr_in = a;
      tick;
      tick;
      check(exp, mem_rdata_out);
   endtask

   // Enable and count end-of-set pulses until the sequence finishes or the limit runs out
   task automatic run(input int limit, output int n_irq, output int n_trig, output int fin);
      n_irq = 0;
      n_trig = 0;
      fin = 0;
      enable_in = 1'b1;
      for (int i = 0; i < limit && fin == 0; i++) begin
         tick;
         n_irq += int'(set_done_irq_out === 1'b1);
         n_trig += int'(dma_trig_out === 1'b1);
         fin = int'(sequence_done_interrupt_out === 1'b1);
      end
   endtask

   initial begin
      #40000;
      fail_count++;
      stop_test;
   end

   initial begin
      void'($urandom(32'h2def41a5));
      repeat (6) @(posedge mclk_in);
      check(64'h0, {busy_out, set_index_out, set_done_irq_out, dma_trig_out,
                    sequence_done_interrupt_out});
      #1;
      nrst_in = 1'b1;
      tick;
      // Source samples in bank 0
      for (int i = 0; i < 8; i++) begin
         // Word 0 has a zero Q half and positive I so the magnitude check fires
         src_words.push_back(i == 0 ? {48'h0, 1'b0, 15'($urandom)} : {$urandom, $urandom});
         mem_wr_in = 1'b1;
         mem_addr_in = 13'(i);
         mem_wdata_in = src_words[i];
         tick;
      end
      mem_wr_in = 1'b0;
      tick;
      for (int i = 0; i < 8; i++) mem_read(13'(i), src_words[i]);
      // Two chained copies, second waits for the DMA, two passes
      set_cfg(4'h0, 32'h0003_0000, 13'h0000, 13'h1000, 12'h008);
      set_cfg(4'h1, 32'h0000_0003, 13'h1000, 13'h1800, 12'h008);
      first_set_index_in = 4'h0;
      last_set_index_in = 4'h1;
      loop_repeat_count_in = 12'h002;
      dma_delay = 4'($urandom_range(0, 15));
      run(2000, irqs, trigs, done);
      check(64'h1, 64'(done));
      check(64'h2, 64'(irqs));
      check(64'h2, 64'(trigs));
      enable_in = 1'b0;
      repeat (3) tick;
      check(64'h0, {63'h0, busy_out});
      for (int i = 0; i < 8; i++) begin
         mem_read(13'h1000 + 13'(i), {32'h0, src_words[i][31:0]});
         mem_read(13'h1800 + 13'(i), {32'h0, src_words[i][31:0]});
      end
      // A zero loop count runs nothing
      loop_repeat_count_in = 12'h000;
      run(40, irqs, trigs, done);
      check(64'h0, {63'h0, busy_out});
      check(64'h0, 64'(done));
      enable_in = 1'b0;
      tick;
      // Every operation, triggers in turn; waiting sets must not start early
      first_set_index_in = 4'h2;
      last_set_index_in = 4'h2;
      loop_repeat_count_in = 12'h001;
      for (int k = 0; k < 6; k++) begin
         trig = 3'(k % 3);
         set_cfg(4'h2, {26'h0, 3'(k), trig}, 13'h0000, 13'h0800, 12'h004);
         if (trig != 3'h0) begin
            run(30, irqs, trigs, done);
            check(64'h0, 64'(done));
            check(64'h1, {63'h0, busy_out});
            check(64'h2, {60'h0, set_index_out});
         end
         sw_trigger_in = (trig == 3'h1);
         adc_switch_in = (trig == 3'h2);
         run(100, irqs, trigs, done);
         check(64'h1, 64'(done));
         sw_trigger_in = 1'b0;
         adc_switch_in = 1'b0;
         enable_in = 1'b0;
         tick;
         for (int j = 0; j < 4; j++) mem_read(13'h0800 + 13'(j), model(k, src_words[j]));
      end
      // Endless looping stops only on abort
      // 32-bit words in and out: low 24 bits of each half come back sign-extended
      set_cfg(4'h2, 32'h0000_00c0, 13'h0001, 13'h0800, 12'h001);
      loop_repeat_count_in = 12'hfff;
      run(300, irqs, trigs, done);
      check(64'h0, 64'(done));
      check(64'h1, {63'h0, busy_out});
      enable_in = 1'b0;
      repeat (3) tick;
      check(64'h0, {63'h0, busy_out});
      mem_read(13'h0800, {{8{src_words[1][55]}}, src_words[1][55:32], {8{src_words[1][23]}},
         src_words[1][23:0]});
      stop_test;
   end
endmodule // testbench
`default_nettype wire
